// >>> core/aoc_pkg.sv
// Constants, register map and types of the analog output channel controller
package aoc_pkg;
	localparam int NCH = 3;
	localparam int NSIG = 16;
	localparam int SRC_W = 5;
	// Source code 0 means not connected; code k selects signal k-1
	localparam logic [4:0] SRC_NONE = 5'h00;
	localparam logic [4:0] SRC_PITCH = 5'h01;

	// Drive values and limits are signed Q16.16 in V or mA
	localparam logic [31:0] LIM_0 = 32'h0000_0000;
	localparam logic [31:0] LIM_4MA = 32'h0004_0000;
	localparam logic [31:0] LIM_5 = 32'h0005_0000;
	localparam logic [31:0] LIM_10 = 32'h000a_0000;
	localparam logic [31:0] LIM_N5 = 32'hfffb_0000;
	localparam logic [31:0] LIM_N10 = 32'hfff6_0000;
	localparam logic [31:0] LIM_20MA = 32'h0014_0000;
	localparam logic [31:0] LIM_24MA = 32'h0018_0000;
	// Scale is signed Q8.24
	localparam int SCALE_FRAC = 24;

	// Output mode codes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_VOLT = 2'h1;
	localparam logic [1:0] MODE_CURR = 2'h2;
	// Voltage ranges
	localparam logic [1:0] VR_0_5 = 2'h0;
	localparam logic [1:0] VR_0_10 = 2'h1;
	localparam logic [1:0] VR_PM5 = 2'h2;
	localparam logic [1:0] VR_PM10 = 2'h3;
	// Current ranges
	localparam logic [1:0] IR_4_20 = 2'h0;
	localparam logic [1:0] IR_0_20 = 2'h1;
	localparam logic [1:0] IR_0_24 = 2'h2;

	// Reset values
	localparam logic [31:0] RST_SCALE = 32'h0007_1c72;
	localparam logic [31:0] RST_OFFSET = 32'h0002_8000;

	// Register map: global page, then one 0x20 page per channel
	localparam logic [11:0] A_INT_STAT = 12'h000;
	localparam logic [11:0] A_INT_MASK = 12'h004;
	localparam logic [11:0] A_GLOBAL = 12'h008;
	localparam logic [11:0] CH_STRIDE = 12'h020;
	localparam logic [2:0] R_CFG = 3'h0;
	localparam logic [2:0] R_SCALE = 3'h1;
	localparam logic [2:0] R_OFFSET = 3'h2;
	localparam logic [2:0] R_STATUS = 3'h3;
	localparam logic [2:0] R_DRIVE = 3'h4;
	// CFG fields
	localparam int F_SRC = 0;
	localparam int F_MODE = 8;
	localparam int F_VR = 12;
	localparam int F_IR = 16;
	// Status bits
	localparam int S_TEMP = 0;
	localparam int S_CURR = 1;
	localparam int S_GLOB = 2;
	// Interrupt bit of the global error event
	localparam int I_GLOB = 3;

	// Timing
	localparam int CLK_NS = 10;
	localparam int PERIOD_NS = 1000;
	localparam int PERIOD_CYC = PERIOD_NS / CLK_NS;
	localparam int SAFE_NS = 10000;
	localparam int SAFE_CYC = (SAFE_NS + CLK_NS - 1) / CLK_NS;
	localparam int REINIT_NS = 100;
	localparam int REINIT_CYC = (REINIT_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		GS_RUN,
		GS_SAFE,
		GS_REINIT,
		GS_WAIT
	} aoc_gstate_e;
endpackage

// >>> core/aoc_top.sv
// Three-channel analog output controller with APB registers
// Operation
// - Three output channels, each configured and run independently.
// - Each channel input selects any internal signal or none.
// - Drive value is input sample times scale plus offset.
// - Channel one defaults: pitch source, scale 0.027777782, offset 2.5, voltage.
// - Voltage ranges 0-5, 0-10, -5-5, -10-10 V; default 0-5 V.
// - Current ranges 4-20, 0-20, 0-24 mA; default 4-20 mA.
// - Undefined input in voltage mode drives zero volts.
// - Undefined input in current mode drives 0 mA, or 4 mA on 4-20.
// - Drive value beyond the range limits is clipped to the limit.
// - Disabled mode puts output in high impedance; value undefined.
// - Each channel publishes its own status word.
// - Status bit 0: converter over-temperature, thermal shutdown.
// - Status bit 1: open circuit or overvoltage in current mode.
// - Status bit 2: internal communication or supply error.
// - Status bits 3 to 31 always read zero.
// - Bit 0 is LSB, bit 31 MSB; one means active.
// - Communication error anywhere: all channels go safe, then re-initialise.
// - Global error holds until every channel is back to normal.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module aoc_top (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [31:0] i_sig_value [aoc_pkg::NSIG],
	input wire logic [aoc_pkg::NSIG-1:0] i_sig_valid,
	input wire logic [aoc_pkg::NCH-1:0] i_conv_overtemp,
	input wire logic [aoc_pkg::NCH-1:0] i_conv_open_fault,
	input wire logic [aoc_pkg::NCH-1:0] i_conv_comm_err,
	input wire logic [aoc_pkg::NCH-1:0] i_conv_supply_err,
	output logic [31:0] o_channel_drive_value [aoc_pkg::NCH],
	output logic [aoc_pkg::NCH-1:0] o_drive_defined,
	output logic [aoc_pkg::NCH-1:0] o_drive_update,
	output logic [aoc_pkg::NCH-1:0] o_out_hiz,
	output logic [aoc_pkg::NCH-1:0] o_out_current,
	output logic [1:0] o_out_range [aoc_pkg::NCH],
	output logic [31:0] o_status [aoc_pkg::NCH],
	output logic o_conv_reinit,
	output logic o_global_err,
	output logic o_irq
);
	localparam int NCH = aoc_pkg::NCH;

	logic [4:0] src_sel [NCH];
	logic [1:0] mode [NCH];
	logic [1:0] vrange [NCH];
	logic [1:0] irange [NCH];
	logic [31:0] scale [NCH];
	logic [31:0] offset [NCH];
	logic [3:0] int_stat;
	logic [3:0] int_mask;
	logic [NCH-1:0] ovt_s1, ovt_s2;
	logic [NCH-1:0] opn_s1, opn_s2;
	logic [NCH-1:0] com_s1, com_s2;
	logic [NCH-1:0] sup_s1, sup_s2;
	aoc_pkg::aoc_gstate_e gstate;
	logic [15:0] gcnt;
	logic [15:0] pcnt;
	logic tick;
	logic [31:0] next_drive [NCH];
	logic [NCH-1:0] next_defined;
	logic [31:0] next_status [NCH];
	logic [NCH-1:0] stat_evt;
	logic glob_evt;
	logic acc;
	logic wr;
	logic [1:0] pg;
	logic [2:0] rsel;
	logic [1:0] ch;
	logic hit;
	logic [31:0] rdata;

	// Converter fault pins are asynchronous
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ovt_s1 <= '0;
			ovt_s2 <= '0;
			opn_s1 <= '0;
			opn_s2 <= '0;
			com_s1 <= '0;
			com_s2 <= '0;
			sup_s1 <= '0;
			sup_s2 <= '0;
		end else begin
			ovt_s1 <= i_conv_overtemp;
			ovt_s2 <= ovt_s1;
			opn_s1 <= i_conv_open_fault;
			opn_s2 <= opn_s1;
			com_s1 <= i_conv_comm_err;
			com_s2 <= com_s1;
			sup_s1 <= i_conv_supply_err;
			sup_s2 <= sup_s1;
		end
	end

	// Processing period tick
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pcnt <= '0;
			tick <= 1'b0;
		end else if (pcnt == 16'(aoc_pkg::PERIOD_CYC - 1)) begin
			pcnt <= '0;
			tick <= 1'b1;
		end else begin
			pcnt <= pcnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	// Global recovery sequence shared by all channels
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			gstate <= aoc_pkg::GS_RUN;
			gcnt <= '0;
			o_conv_reinit <= 1'b0;
		end else begin
			unique case (gstate)
			aoc_pkg::GS_RUN: begin
				gcnt <= '0;
				o_conv_reinit <= 1'b0;
				if (|com_s2)
					gstate <= aoc_pkg::GS_SAFE;
			end
			aoc_pkg::GS_SAFE: begin
				if (gcnt == 16'(aoc_pkg::SAFE_CYC - 1)) begin
					gcnt <= '0;
					o_conv_reinit <= 1'b1;
					gstate <= aoc_pkg::GS_REINIT;
				end else begin
					gcnt <= gcnt + 16'h0001;
				end
			end
			aoc_pkg::GS_REINIT: begin
				if (gcnt == 16'(aoc_pkg::REINIT_CYC - 1)) begin
					gcnt <= '0;
					o_conv_reinit <= 1'b0;
					gstate <= aoc_pkg::GS_WAIT;
				end else begin
					gcnt <= gcnt + 16'h0001;
				end
			end
			aoc_pkg::GS_WAIT: begin
				// Every channel must be clean, not only the failing one
				if (|com_s2)
					gstate <= aoc_pkg::GS_SAFE;
				else
					gstate <= aoc_pkg::GS_RUN;
			end
			endcase
		end
	end

	function automatic logic signed [39:0] sx(input logic [31:0] v);
		sx = {{8{v[31]}}, v};
	endfunction

	// Per-channel arithmetic, clipping and status word
	always_comb begin
		logic signed [63:0] prod;
		logic signed [39:0] sum;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] safe;
		logic [4:0] k;
		logic def;
		prod = '0;
		sum = '0;
		lo = '0;
		hi = '0;
		safe = '0;
		k = '0;
		def = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			if (mode[c] == aoc_pkg::MODE_CURR) begin
				unique case (irange[c])
				aoc_pkg::IR_0_20: begin
					lo = aoc_pkg::LIM_0;
					hi = aoc_pkg::LIM_20MA;
				end
				aoc_pkg::IR_0_24: begin
					lo = aoc_pkg::LIM_0;
					hi = aoc_pkg::LIM_24MA;
				end
				default: begin
					lo = aoc_pkg::LIM_4MA;
					hi = aoc_pkg::LIM_20MA;
				end
				endcase
			end else begin
				unique case (vrange[c])
				aoc_pkg::VR_0_5: begin
					lo = aoc_pkg::LIM_0;
					hi = aoc_pkg::LIM_5;
				end
				aoc_pkg::VR_0_10: begin
					lo = aoc_pkg::LIM_0;
					hi = aoc_pkg::LIM_10;
				end
				aoc_pkg::VR_PM5: begin
					lo = aoc_pkg::LIM_N5;
					hi = aoc_pkg::LIM_5;
				end
				aoc_pkg::VR_PM10: begin
					lo = aoc_pkg::LIM_N10;
					hi = aoc_pkg::LIM_10;
				end
				endcase
			end
			// Safe level: 0 V, 0 mA, or 4 mA on the 4-20 mA range
			safe = (mode[c] == aoc_pkg::MODE_CURR &&
				irange[c] == aoc_pkg::IR_4_20) ?
				aoc_pkg::LIM_4MA : aoc_pkg::LIM_0;
			k = src_sel[c] - 5'h01;
			def = (src_sel[c] != aoc_pkg::SRC_NONE) &&
				(src_sel[c] <= 5'(aoc_pkg::NSIG)) &&
				i_sig_valid[k[3:0]];
			prod = $signed(i_sig_value[k[3:0]]) *
				$signed(scale[c]);
			sum = prod[63:24] + sx(offset[c]);
			if (mode[c] == aoc_pkg::MODE_OFF) begin
				next_drive[c] = '0;
				next_defined[c] = 1'b0;
			end else if (gstate != aoc_pkg::GS_RUN || !def) begin
				next_drive[c] = safe;
				next_defined[c] = 1'b1;
			end else if (sum > sx(hi)) begin
				next_drive[c] = hi;
				next_defined[c] = 1'b1;
			end else if (sum < sx(lo)) begin
				next_drive[c] = lo;
				next_defined[c] = 1'b1;
			end else begin
				next_drive[c] = sum[31:0];
				next_defined[c] = 1'b1;
			end
			next_status[c] = '0;
			next_status[c][aoc_pkg::S_TEMP] = ovt_s2[c];
			next_status[c][aoc_pkg::S_CURR] = opn_s2[c] &&
				mode[c] == aoc_pkg::MODE_CURR;
			next_status[c][aoc_pkg::S_GLOB] = sup_s2[c] ||
				gstate != aoc_pkg::GS_RUN;
		end
	end

	// Converter-facing outputs, one lane per channel
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int c = 0; c < NCH; c++) begin
				o_channel_drive_value[c] <= '0;
				o_out_range[c] <= '0;
				o_status[c] <= '0;
			end
			o_drive_defined <= '0;
			o_drive_update <= '0;
			o_out_hiz <= '1;
			o_out_current <= '0;
			o_global_err <= 1'b0;
			stat_evt <= '0;
			glob_evt <= 1'b0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				// Safe level must not wait for the next period
				if (tick || gstate != aoc_pkg::GS_RUN) begin
					o_channel_drive_value[c] <= next_drive[c];
					o_drive_defined[c] <= next_defined[c];
				end
				o_drive_update[c] <= tick;
				o_out_hiz[c] <= mode[c] == aoc_pkg::MODE_OFF;
				o_out_current[c] <= mode[c] == aoc_pkg::MODE_CURR;
				o_out_range[c] <= (mode[c] == aoc_pkg::MODE_CURR) ?
					irange[c] : vrange[c];
				o_status[c] <= next_status[c];
				stat_evt[c] <= |(next_status[c] & ~o_status[c]);
			end
			o_global_err <= gstate != aoc_pkg::GS_RUN;
			glob_evt <= gstate != aoc_pkg::GS_RUN && !o_global_err;
		end
	end

	// APB: one wait state, response registered
	assign acc = i_psel && i_penable;
	assign wr = acc && o_pready && i_pwrite;
	assign pg = i_paddr[6:5];
	assign rsel = i_paddr[4:2];
	assign ch = pg - 2'h1;

	always_comb begin
		rdata = '0;
		hit = 1'b0;
		if (i_paddr[11:7] == 5'h00 && i_paddr[1:0] == 2'h0) begin
			if (pg == 2'h0) begin
				unique case (i_paddr)
				aoc_pkg::A_INT_STAT: begin
					rdata = {28'h0, int_stat};
					hit = 1'b1;
				end
				aoc_pkg::A_INT_MASK: begin
					rdata = {28'h0, int_mask};
					hit = 1'b1;
				end
				aoc_pkg::A_GLOBAL: begin
					rdata = {31'h0, o_global_err};
					hit = 1'b1;
				end
				default: ;
				endcase
			end else begin
				hit = 1'b1;
				unique case (rsel)
				aoc_pkg::R_CFG: begin
					rdata[aoc_pkg::F_SRC +: 5] = src_sel[ch];
					rdata[aoc_pkg::F_MODE +: 2] = mode[ch];
					rdata[aoc_pkg::F_VR +: 2] = vrange[ch];
					rdata[aoc_pkg::F_IR +: 2] = irange[ch];
				end
				aoc_pkg::R_SCALE: rdata = scale[ch];
				aoc_pkg::R_OFFSET: rdata = offset[ch];
				aoc_pkg::R_STATUS: rdata = o_status[ch];
				aoc_pkg::R_DRIVE: rdata = o_channel_drive_value[ch];
				default: hit = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pready <= 1'b0;
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= acc && !o_pready;
			o_pslverr <= acc && !o_pready && !hit;
			if (acc && !o_pready)
				o_prdata <= (hit && !i_pwrite) ? rdata : '0;
		end
	end

	// Channel configuration
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int c = 0; c < NCH; c++) begin
				src_sel[c] <= (c == 0) ? aoc_pkg::SRC_PITCH :
					aoc_pkg::SRC_NONE;
				mode[c] <= aoc_pkg::MODE_VOLT;
				vrange[c] <= aoc_pkg::VR_0_5;
				irange[c] <= aoc_pkg::IR_4_20;
				scale[c] <= aoc_pkg::RST_SCALE;
				offset[c] <= aoc_pkg::RST_OFFSET;
			end
		end else if (wr && hit && pg != 2'h0) begin
			unique case (rsel)
			aoc_pkg::R_CFG: begin
				src_sel[ch] <= i_pwdata[aoc_pkg::F_SRC +: 5];
				// Reserved mode code falls back to disabled
				mode[ch] <= (i_pwdata[aoc_pkg::F_MODE +: 2] == 2'h3) ?
					aoc_pkg::MODE_OFF : i_pwdata[aoc_pkg::F_MODE +: 2];
				vrange[ch] <= i_pwdata[aoc_pkg::F_VR +: 2];
				irange[ch] <= (i_pwdata[aoc_pkg::F_IR +: 2] == 2'h3) ?
					aoc_pkg::IR_4_20 : i_pwdata[aoc_pkg::F_IR +: 2];
			end
			aoc_pkg::R_SCALE: scale[ch] <= i_pwdata;
			aoc_pkg::R_OFFSET: offset[ch] <= i_pwdata;
			default: ;
			endcase
		end
	end

	// Interrupts: sticky, set wins over write-one-to-clear
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			int_stat <= '0;
			int_mask <= '0;
			o_irq <= 1'b0;
		end else begin
			if (wr && i_paddr == aoc_pkg::A_INT_MASK)
				int_mask <= i_pwdata[3:0];
			int_stat <= (int_stat & ~((wr &&
				i_paddr == aoc_pkg::A_INT_STAT) ? i_pwdata[3:0] : 4'h0))
				| {glob_evt, stat_evt};
			o_irq <= |(int_stat & int_mask);
		end
	end
endmodule

// >>> test/aoc_top_checker.sv
// Port-level checker of the analog output channel controller
`timescale 1ns/1ns
module aoc_top_checker (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic [aoc_pkg::NCH-1:0] i_conv_overtemp,
	input wire logic [aoc_pkg::NCH-1:0] i_conv_open_fault,
	input wire logic [31:0] o_channel_drive_value [aoc_pkg::NCH],
	input wire logic [aoc_pkg::NCH-1:0] o_drive_update,
	input wire logic [aoc_pkg::NCH-1:0] o_out_hiz,
	input wire logic [aoc_pkg::NCH-1:0] o_out_current,
	input wire logic [31:0] o_status [aoc_pkg::NCH],
	input wire logic o_conv_reinit,
	input wire logic o_global_err
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	AST_APB_WAIT: assert property (
		$rose(i_penable) && i_psel |=> o_pready ##1 !o_pready
	) else $error("ready not one pulse after one wait state");
	AST_RSVD: assert property (
		(o_status[0][31:3] | o_status[1][31:3] | o_status[2][31:3]) == 29'h0
	) else $error("reserved status bit set");
	// Three samples cover the two-stage synchroniser plus the flag register
	AST_TEMP: assert property (
		i_conv_overtemp[0] [*3] |=> o_status[0][0]
	) else $error("over-temperature not flagged");
	AST_TEMP_OFF: assert property (
		(!i_conv_overtemp[0]) [*3] |=> !o_status[0][0]
	) else $error("temperature flag without cause");
	AST_OPEN: assert property (
		(i_conv_open_fault[0] && o_out_current[0]) [*4] |=> o_status[0][1]
	) else $error("current output fault not flagged");
	AST_GLOB: assert property (
		o_global_err |-> o_status[0][2] && o_status[1][2] && o_status[2][2]
	) else $error("global flag missing on a channel");
	AST_SAFE_V: assert property (
		$rose(o_global_err) && !o_out_current[0] && !o_out_hiz[0]
		|-> o_channel_drive_value[0] == aoc_pkg::LIM_0
	) else $error("voltage channel not at safe level");
	AST_REINIT: assert property (
		$rose(o_conv_reinit) |-> o_global_err ##9 o_conv_reinit ##1 !o_conv_reinit
	) else $error("re-initialisation pulse wrong");
	AST_UPD_GAP: assert property (
		o_drive_update[0] |=> (!o_drive_update[0]) [*8]
	) else $error("drive update repeats too soon");
	AST_UPD_PER: assert property (
		o_drive_update[0] && !o_global_err
		|-> ##100 (o_drive_update[0] || o_global_err)
	) else $error("drive update period wrong");
endmodule

bind aoc_top aoc_top_checker u_chk (
	.i_core_clk, .i_rst_b, .i_psel, .i_penable, .o_pready,
	.i_conv_overtemp, .i_conv_open_fault, .o_channel_drive_value,
	.o_drive_update, .o_out_hiz, .o_out_current, .o_status,
	.o_conv_reinit, .o_global_err
);

// >>> test/aoc_conv_model.sv
// Behavioural converter chips, one for each analog output channel
`timescale 1ns/1ns
module aoc_conv_model (
	input wire logic [2:0] i_out_current,
	input wire logic [2:0] i_out_hiz,
	input wire logic [2:0] i_hot,
	input wire logic [2:0] i_open_load,
	input wire logic [2:0] i_link_bad,
	input wire logic [2:0] i_supply_bad,
	output logic [2:0] o_overtemp,
	output logic [2:0] o_open_fault,
	output logic [2:0] o_comm_err,
	output logic [2:0] o_supply_err
);
	// Thermal shutdown is reported for as long as the die stays hot
	assign o_overtemp = i_hot;
	// An open loop only shows while current is actually driven
	assign o_open_fault = i_open_load & i_out_current & ~i_out_hiz;
	assign o_comm_err = i_link_bad;
	assign o_supply_err = i_supply_bad;
endmodule

// >>> test/tb_aoc_top.sv
// Self-checking bench of the analog output channel controller
`timescale 1ns/1ns
module tb_aoc_top;
	logic i_core_clk, i_rst_b, i_psel, i_penable, i_pwrite, err;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, q;
	logic o_pready, o_pslverr, o_conv_reinit, o_global_err, o_irq;
	logic [31:0] i_sig_value [aoc_pkg::NSIG];
	logic [aoc_pkg::NSIG-1:0] i_sig_valid;
	logic [31:0] o_channel_drive_value [aoc_pkg::NCH];
	logic [31:0] o_status [aoc_pkg::NCH];
	logic [1:0] o_out_range [aoc_pkg::NCH];
	logic [2:0] i_conv_overtemp, i_conv_open_fault, i_conv_comm_err;
	logic [2:0] i_conv_supply_err, o_drive_defined, o_drive_update;
	logic [2:0] o_out_hiz, o_out_current, hot, opl, bad, sup;
	int n_mismatch, n_checks;

	aoc_top u_dut (
		.i_core_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sig_value,
		.i_sig_valid, .i_conv_overtemp, .i_conv_open_fault,
		.i_conv_comm_err, .i_conv_supply_err, .o_channel_drive_value,
		.o_drive_defined, .o_drive_update, .o_out_hiz, .o_out_current,
		.o_out_range, .o_status, .o_conv_reinit, .o_global_err, .o_irq
	);
	aoc_conv_model u_conv (
		.i_out_current(o_out_current), .i_out_hiz(o_out_hiz), .i_hot(hot),
		.i_open_load(opl), .i_link_bad(bad), .i_supply_bad(sup),
		.o_overtemp(i_conv_overtemp), .o_open_fault(i_conv_open_fault),
		.o_comm_err(i_conv_comm_err), .o_supply_err(i_conv_supply_err)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	function automatic logic [11:0] ra(input int c, input logic [2:0] r);
		return aoc_pkg::CH_STRIDE * 12'(c + 1) + {7'h0, r, 2'h0};
	endfunction

	// Starts one edge late so a strobe is never set twice in one step
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge i_core_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (o_pready !== 1'b1) begin
			n_mismatch++;
			final_report();
		end
		q = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	function automatic logic peek(input int s);
		case (s)
			0: return o_drive_update[0];
			1: return o_global_err;
			default: return o_conv_reinit;
		endcase
	endfunction

	task automatic wait_for(input int s, input logic v, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (peek(s) !== v && n < lim);
		if (peek(s) !== v) begin
			n_mismatch++;
			final_report();
		end
	endtask

	// Two refreshes, so the first one may still use the old setting
	task automatic chk_drv(input logic [4:0] s, input logic [1:0] m,
		input logic [1:0] r, input logic [31:0] x, input logic [31:0] e);
		apb(1'b1, ra(0, aoc_pkg::R_CFG), {14'h0, r, 2'h0, r, 2'h0, m, 3'h0, s});
		if (s != 5'h0) begin
			i_sig_value[s - 5'h1] <= x;
		end
		wait_for(0, 1'b1, 300);
		wait_for(0, 1'b1, 300);
		cmp(32'(o_out_hiz[0]), 32'(m == aoc_pkg::MODE_OFF));
		if (m != aoc_pkg::MODE_OFF) begin
			cmp(o_channel_drive_value[0], e);
			cmp(32'(o_out_range[0]), 32'(r));
			cmp(32'(o_out_current[0]), 32'(m == aoc_pkg::MODE_CURR));
		end
	endtask

	initial begin
		n_mismatch = 0;
		n_checks = 0;
		i_rst_b = 1'b0;
		{i_psel, i_penable, i_pwrite} = 3'h0;
		i_paddr = 12'h000;
		i_pwdata = 32'h0;
		i_sig_valid = '1;
		{hot, opl, bad, sup} = 12'h000;
		foreach (i_sig_value[k]) begin
			i_sig_value[k] = 32'h000a_0000;
		end
		repeat (20) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		for (int c = 0; c < 3; c++) begin
			apb(1'b0, ra(c, aoc_pkg::R_CFG), 32'h0);
			cmp(q, c == 0 ? 32'h0000_0101 : 32'h0000_0100);
			apb(1'b0, ra(c, aoc_pkg::R_SCALE), 32'h0);
			cmp(q, aoc_pkg::RST_SCALE);
			apb(1'b0, ra(c, aoc_pkg::R_OFFSET), 32'h0);
			cmp(q, aoc_pkg::RST_OFFSET);
		end
		apb(1'b0, 12'hffc, 32'h0);
		cmp(32'(err), 32'h1);
		apb(1'b1, ra(0, aoc_pkg::R_SCALE), 32'h0080_0000);
		apb(1'b1, ra(0, aoc_pkg::R_OFFSET), 32'h0001_0000);
		chk_drv(5'h1, 2'h1, 2'h3, 32'h0004_0000, 32'h0003_0000);
		apb(1'b1, ra(0, aoc_pkg::R_SCALE), 32'h0100_0000);
		apb(1'b1, ra(0, aoc_pkg::R_OFFSET), 32'h0);
		chk_drv(5'h5, 2'h1, 2'h3, 32'hfffe_0000, 32'hfffe_0000);
		chk_drv(5'h1, 2'h1, 2'h0, 32'h000c_0000, aoc_pkg::LIM_5);
		chk_drv(5'h1, 2'h1, 2'h1, 32'h000c_0000, aoc_pkg::LIM_10);
		chk_drv(5'h1, 2'h1, 2'h2, 32'hfff4_0000, aoc_pkg::LIM_N5);
		chk_drv(5'h1, 2'h1, 2'h3, 32'hfff4_0000, aoc_pkg::LIM_N10);
		chk_drv(5'h1, 2'h2, 2'h2, 32'h001e_0000, aoc_pkg::LIM_24MA);
		chk_drv(5'h1, 2'h2, 2'h0, 32'hffe2_0000, aoc_pkg::LIM_4MA);
		chk_drv(5'h1, 2'h2, 2'h1, 32'hffe2_0000, aoc_pkg::LIM_0);
		chk_drv(5'h0, 2'h1, 2'h3, 32'h0, aoc_pkg::LIM_0);
		chk_drv(5'h0, 2'h2, 2'h0, 32'h0, aoc_pkg::LIM_4MA);
		chk_drv(5'h0, 2'h2, 2'h2, 32'h0, aoc_pkg::LIM_0);
		i_sig_valid[0] <= 1'b0;
		chk_drv(5'h1, 2'h1, 2'h0, 32'h0003_0000, aoc_pkg::LIM_0);
		i_sig_valid[0] <= 1'b1;
		chk_drv(5'h1, 2'h0, 2'h0, 32'h0003_0000, 32'h0);
		cmp(32'(o_drive_defined[0]), 32'h0);
		hot <= 3'b001;
		repeat (4) @(posedge i_core_clk);
		cmp(o_status[0], 32'h0000_0001);
		cmp(o_status[1], 32'h0);
		cmp(32'(o_irq), 32'h0);
		apb(1'b0, ra(0, aoc_pkg::R_STATUS), 32'h0);
		cmp(q, 32'h0000_0001);
		apb(1'b1, aoc_pkg::A_INT_MASK, 32'h0000_0001);
		// Mask lands at the completing edge, irq register one edge later
		repeat (2) @(posedge i_core_clk);
		cmp(32'(o_irq), 32'h1);
		hot <= 3'b000;
		apb(1'b1, aoc_pkg::A_INT_STAT, 32'h0000_00ff);
		apb(1'b1, ra(0, aoc_pkg::R_CFG), 32'h0000_0201);
		opl <= 3'b001;
		apb(1'b0, aoc_pkg::A_INT_STAT, 32'h0);
		cmp(q, 32'h0);
		cmp(32'(o_irq), 32'h0);
		// Mode register, then output pin, then two sync stages
		repeat (2) @(posedge i_core_clk);
		cmp(o_status[0], 32'h0000_0002);
		opl <= 3'b000;
		apb(1'b1, ra(1, aoc_pkg::R_SCALE), 32'h0100_0000);
		apb(1'b1, ra(1, aoc_pkg::R_OFFSET), 32'h0);
		apb(1'b1, ra(1, aoc_pkg::R_CFG), 32'h0000_0202);
		apb(1'b1, ra(0, aoc_pkg::R_CFG), 32'h0000_0101);
		wait_for(0, 1'b1, 300);
		wait_for(0, 1'b1, 300);
		cmp(o_channel_drive_value[1], 32'h000a_0000);
		bad <= 3'b110;
		wait_for(1, 1'b1, 10);
		cmp(o_channel_drive_value[0], aoc_pkg::LIM_0);
		cmp(o_channel_drive_value[1], aoc_pkg::LIM_4MA);
		cmp(o_status[0], 32'h0000_0004);
		wait_for(2, 1'b1, 1200);
		bad <= 3'b010;
		wait_for(2, 1'b0, 20);
		wait_for(2, 1'b1, 1200);
		cmp(32'(o_global_err), 32'h1);
		bad <= 3'b000;
		wait_for(1, 1'b0, 1300);
		cmp(o_status[2], 32'h0);
		apb(1'b0, aoc_pkg::A_INT_STAT, 32'h0);
		cmp(q & 32'h0000_0008, 32'h0000_0008);
		sup <= 3'b010;
		repeat (4) @(posedge i_core_clk);
		cmp(o_status[1], 32'h0000_0004);
		cmp(32'(o_global_err), 32'h0);
		final_report();
	end
endmodule
